/* hw/lsc_cycle_ctrl.sv */
// measurement cycle controller: enables, integration and wait timers, low threshold
module lsc_cycle_ctrl #(
    parameter int unsigned STEP_CYCLES = lsc_pkg::STEP_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire lsc_pkg::lsc_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic wait_stretch_i,
    input wire logic int_enable_i,
    input wire logic [3:0] persistence_count_i,
    input wire logic [15:0] ch0_result_i,
    input wire logic int_clear_i,
    output logic osc_run_o,
    output logic measure_active_o,
    output logic integrating_o,
    output logic autozero_o,
    output logic result_valid_o,
    output logic [15:0] ch0_value_o,
    output logic [15:0] low_limit_o,
    output logic light_int_o,
    output logic int_pin_o,
    output logic int_pin_oe_o
);
    import lsc_pkg::*;

    localparam logic [23:0] STEP_LEN = 24'(STEP_CYCLES);
    localparam logic [23:0] STEP_LEN_LONG = 24'(STEP_CYCLES * WAIT_STRETCH_FACTOR);

    logic [7:0] enable_reg;
    logic [7:0] integration_length;
    logic [7:0] wait_length;
    logic [7:0] low_limit_lsb;
    logic [15:0] low_limit;
    lsc_state_t state;
    lsc_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [23:0] presc;
    logic [5:0] below_cnt;
    logic az_pending;
    logic result_valid;
    logic [15:0] ch0_value;
    logic light_int;

    // register port decode
    wire wr_enable = reg_req_i.wr && reg_req_i.addr == ADDR_POWER_AND_FUNCTION_ENABLE;
    wire wr_integ = reg_req_i.wr && reg_req_i.addr == ADDR_INTEGRATION_LENGTH;
    wire wr_wait = reg_req_i.wr && reg_req_i.addr == ADDR_WAIT_LENGTH;
    wire wr_lsb = reg_req_i.wr && reg_req_i.addr == ADDR_LOW_LIMIT_LSB;
    wire wr_msb = reg_req_i.wr && reg_req_i.addr == ADDR_LOW_LIMIT_MSB;

    // enable bits steer the sequencer
    wire oscillator_power_on = enable_reg[BIT_OSCILLATOR_POWER_ON];
    wire light_measure_on = enable_reg[BIT_LIGHT_MEASURE_ON];
    wire wen = enable_reg[BIT_WAIT_TIMER_ON];
    wire run = oscillator_power_on && light_measure_on; // measurement without the oscillator is never started

    // oscillator bit rising with measure set in the same write arms the auto-zero pass
    wire az_arm = wr_enable && !oscillator_power_on && reg_req_i.wdata[BIT_OSCILLATOR_POWER_ON]
        && reg_req_i.wdata[BIT_LIGHT_MEASURE_ON];

    // step timer: a wait step is stretched twelvefold when asked
    wire [23:0] step_len = (state == LSC_WAIT && wait_stretch_i) ? STEP_LEN_LONG : STEP_LEN;
    // at or past the end, so a stretch dropped mid-step cannot let the prescaler run on and wrap
    wire step_tick = presc >= step_len - 24'h000001;
    wire phase_end = step_tick && cnt == 8'h00; // terminal count of either down counter
    wire integ_end = state == LSC_INTEG && phase_end && run;

    // saturating result: (steps << 10) - 1, capped at full scale
    wire [8:0] steps = {1'b0, integration_length} + 9'h001;
    wire [18:0] max_raw = {steps, 10'h000} - 19'h00001;
    wire [15:0] max_value = (max_raw > {3'h0, RESULT_FULL_SCALE}) ? RESULT_FULL_SCALE : max_raw[15:0];
    wire [15:0] clamped = (ch0_result_i > max_value) ? max_value : ch0_result_i;

    // persistence filter target from the code: 1..3 literal, then steps of five
    wire [5:0] pers_code = {2'h0, persistence_count_i};
    wire [5:0] pers_target = (pers_code < 6'h04) ? pers_code : 6'((pers_code - 6'h03) * 6'h05);
    wire below = clamped < low_limit;
    // saturating, so a long run below the limit never wraps back under the target
    wire [5:0] below_next = below ? ((below_cnt == 6'h3f) ? below_cnt : below_cnt + 6'h01) : 6'h00;
    wire int_event = integ_end && (pers_code == 6'h00 || (below && below_next >= pers_target));

    // read mux; unmapped offsets read as zero
    wire [7:0] rdata_mux =
        (reg_req_i.addr == ADDR_POWER_AND_FUNCTION_ENABLE) ? enable_reg :
        (reg_req_i.addr == ADDR_INTEGRATION_LENGTH) ? integration_length :
        (reg_req_i.addr == ADDR_WAIT_LENGTH) ? wait_length :
        (reg_req_i.addr == ADDR_LOW_LIMIT_LSB) ? low_limit_lsb :
        (reg_req_i.addr == ADDR_LOW_LIMIT_MSB) ? low_limit[15:8] : 8'h00;

    // sequencer: integrate, optionally wait, repeat
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            LSC_IDLE: begin
                if (run) begin
                    next_state = LSC_INTEG;
                    next_cnt = integration_length;
                end
            end
            LSC_INTEG: begin
                if (!run) begin
                    next_state = LSC_IDLE;
                end else if (phase_end && wen) begin
                    next_state = LSC_WAIT;
                    next_cnt = wait_length;
                end else if (phase_end) begin
                    next_cnt = integration_length; // back-to-back integrations
                end else if (step_tick) begin
                    next_cnt = cnt - 8'h01;
                end
            end
            LSC_WAIT: begin
                if (!run) begin
                    next_state = LSC_IDLE;
                end else if (phase_end) begin
                    next_state = LSC_INTEG;
                    next_cnt = integration_length;
                end else if (step_tick) begin
                    next_cnt = cnt - 8'h01;
                end
            end
            default: begin
                next_state = LSC_IDLE;
                next_cnt = 8'h00;
            end
        endcase
    end

    // register file; writes to reserved enable bits are dropped
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            enable_reg <= RST_POWER_AND_FUNCTION_ENABLE;
            integration_length <= RST_INTEGRATION_LENGTH;
            wait_length <= RST_WAIT_LENGTH;
            low_limit_lsb <= RST_LOW_LIMIT_LSB;
            low_limit <= {RST_LOW_LIMIT_MSB, RST_LOW_LIMIT_LSB};
        end else begin
            if (wr_enable) enable_reg <= reg_req_i.wdata & ENABLE_WRITABLE_MASK;
            if (wr_integ) integration_length <= reg_req_i.wdata;
            if (wr_wait) wait_length <= reg_req_i.wdata;
            if (wr_lsb) low_limit_lsb <= reg_req_i.wdata;
            if (wr_msb) low_limit <= {reg_req_i.wdata, low_limit_lsb}; // no half-updated threshold
        end
    end

    // sequencer state and step prescaler
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= LSC_IDLE;
            cnt <= 8'h00;
            presc <= 24'h000000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            presc <= (state == LSC_IDLE || step_tick) ? 24'h000000 : presc + 24'h000001;
        end
    end

    // auto-zero request held until the first integration begins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            az_pending <= 1'b0;
            autozero_o <= 1'b0;
        end else begin
            az_pending <= az_arm || (az_pending && state != LSC_INTEG);
            autozero_o <= az_pending && state == LSC_IDLE && next_state == LSC_INTEG;
        end
    end

    // result capture, persistence count and sticky flag; a new event beats a clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            result_valid <= 1'b0;
            ch0_value <= 16'h0000;
            below_cnt <= 6'h00;
            light_int <= 1'b0;
        end else begin
            result_valid <= integ_end;
            if (integ_end) ch0_value <= clamped;
            if (integ_end) below_cnt <= below_next;
            light_int <= int_event || (light_int && !int_clear_i);
        end
    end

    assign reg_rdata_o = rdata_mux;
    assign osc_run_o = oscillator_power_on;
    assign measure_active_o = state != LSC_IDLE;
    assign integrating_o = state == LSC_INTEG;
    assign result_valid_o = result_valid;
    assign ch0_value_o = ch0_value;
    assign low_limit_o = low_limit;
    assign light_int_o = light_int;
    // open drain, active low: drive low only while flagged and enabled
    assign int_pin_o = 1'b0;
    assign int_pin_oe_o = light_int && int_enable_i;

    // check aid: cycles spent in the running phase, cleared at every phase change or end
    // 28 bits so a stretched 256-step wait at the full step length still fits
    logic [27:0] phase_cycles;
    wire [27:0] integ_span = 28'(steps) * 28'(STEP_CYCLES);
    wire [8:0] wait_steps = {1'b0, wait_length} + 9'h001;
    wire [27:0] wait_mult = wait_stretch_i ? 28'(WAIT_STRETCH_FACTOR) : 28'h0000001;
    wire [27:0] wait_span = 28'(wait_steps) * 28'(STEP_CYCLES) * wait_mult;

    // phase length counter; only the checks read it, nothing in the datapath does
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            phase_cycles <= 28'h0000000;
        end else begin
            phase_cycles <= (next_state != state || phase_end) ? 28'h0000000 : phase_cycles + 28'h0000001;
        end
    end

    // checks; the phase checks assume the host leaves lengths and stretch alone
    // while a phase runs, as parameters belong in place before measure-on
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // register port: the oscillator and wait timer enable bits and the threshold bytes land as written
    // and the low threshold never shows half of a new pair
    osc_follow_a: assert property (wr_enable |=> osc_run_o == $past(reg_req_i.wdata[BIT_OSCILLATOR_POWER_ON]))
        else $error("oscillator run does not follow write");
    wen_follow_a: assert property (wr_enable |=> wen == $past(reg_req_i.wdata[BIT_WAIT_TIMER_ON]))
        else $error("wait timer enable does not follow write");
    lsb_store_a: assert property (wr_lsb |=> low_limit_lsb == $past(reg_req_i.wdata))
        else $error("low byte not stored");
    limit_atomic_a: assert property (!$past(wr_msb) |-> $stable(low_limit))
        else $error("threshold changed without high byte write");
    msb_apply_a: assert property (wr_msb |=> low_limit == {$past(reg_req_i.wdata), $past(low_limit_lsb)})
        else $error("threshold pair not applied together");

    // sequencer: starts only with both enables, loads each counter from its length,
    // and only the wait phase ever sees a stretched step
    no_run_idle_a: assert property (!run |=> state == LSC_IDLE)
        else $error("sequencer left running without both enables");
    onehot_state_a: assert property ($onehot(state))
        else $error("sequencer state is not one-hot");
    start_integ_a: assert property ($rose(run) |=> integrating_o)
        else $error("measurement did not start");
    az_start_a: assert property (autozero_o |-> integrating_o && $past(state == LSC_IDLE))
        else $error("auto-zero not at the start of an integration");
    az_once_a: assert property (autozero_o |=> !autozero_o)
        else $error("auto-zero pulse too long");
    integ_load_a: assert property ($rose(state == LSC_INTEG) |-> cnt == $past(integration_length))
        else $error("integration counter not loaded from integration length");
    step_down_a: assert property (step_tick && cnt != 8'h00 && run && state != LSC_IDLE |=> cnt == $past(cnt) - 8'h01)
        else $error("down counter did not step");
    short_integ_a: assert property (integrating_o && step_tick |-> presc == STEP_LEN - 24'h000001)
        else $error("integration step stretched");
    wait_needs_en_a: assert property ($rose(state == LSC_WAIT) |-> $past(wen) && $past(integ_end))
        else $error("wait entered without the wait timer on");
    wait_load_a: assert property ($rose(state == LSC_WAIT) |-> cnt == $past(wait_length))
        else $error("wait counter not loaded from wait length");
    wait_exit_a: assert property ($fell(state == LSC_WAIT) && $past(run) |-> integrating_o)
        else $error("wait not followed by an integration");

    // phase lengths in clock cycles, counted independently of the prescaler
    // against steps times the step length
    integ_span_a: assert property (integ_end |-> phase_cycles == integ_span - 28'h0000001)
        else $error("integration length wrong");
    wait_span_a: assert property (state == LSC_WAIT && phase_end && run |-> phase_cycles == wait_span - 28'h0000001)
        else $error("wait length wrong");

    // result and interrupt: a result only while measuring, held between results,
    // and a flag that an event sets even against a clear
    integ_result_a: assert property (integ_end |=> result_valid_o && ch0_value_o <= $past(max_value))
        else $error("result missing or above saturation");
    result_hold_a: assert property (!integ_end |=> $stable(ch0_value_o))
        else $error("result changed without an integration end");
    result_in_run_a: assert property (result_valid_o |-> measure_active_o)
        else $error("result strobe while idle");
    flag_sets_a: assert property (int_event |=> light_int_o)
        else $error("event lost against clear");
    flag_clear_a: assert property (light_int_o && int_clear_i && !int_event |=> !light_int_o)
        else $error("flag not cleared");
    pin_follow_a: assert property (int_event && int_enable_i ##1 int_enable_i |-> int_pin_oe_o && !int_pin_o)
        else $error("interrupt pin not pulled after event");

    // scenarios worth seeing: wait phases, events, auto-zero, saturation
    // and a persistence filter longer than one result
    cov_wait_c: cover property ($rose(state == LSC_WAIT));
    cov_int_c: cover property (int_event);
    cov_az_c: cover property (autozero_o);
    cov_sat_c: cover property (integ_end && ch0_result_i > max_value);
    cov_pers_c: cover property (int_event && pers_target > 6'h01);

endmodule

/* inc/lsc_pkg.sv */
// package for the light sensor measurement cycle controller
package lsc_pkg;

    // register offsets as seen by the serial register port
    localparam logic [7:0] ADDR_POWER_AND_FUNCTION_ENABLE = 8'h80;
    localparam logic [7:0] ADDR_INTEGRATION_LENGTH = 8'h81;
    localparam logic [7:0] ADDR_WAIT_LENGTH = 8'h83;
    localparam logic [7:0] ADDR_LOW_LIMIT_LSB = 8'h84;
    localparam logic [7:0] ADDR_LOW_LIMIT_MSB = 8'h85;

    // reset values
    localparam logic [7:0] RST_POWER_AND_FUNCTION_ENABLE = 8'h00;
    localparam logic [7:0] RST_INTEGRATION_LENGTH = 8'h00;
    localparam logic [7:0] RST_WAIT_LENGTH = 8'h00;
    localparam logic [7:0] RST_LOW_LIMIT_LSB = 8'h00;
    localparam logic [7:0] RST_LOW_LIMIT_MSB = 8'h00;

    // enable register field positions
    localparam int unsigned BIT_OSCILLATOR_POWER_ON = 0;
    localparam int unsigned BIT_LIGHT_MEASURE_ON = 1;
    localparam int unsigned BIT_WAIT_TIMER_ON = 3;
    localparam logic [7:0] ENABLE_WRITABLE_MASK = 8'h0b;

    // timing: one step of the integration and wait timers
    localparam real CLK_MHZ = 20.0;
    localparam real STEP_MS = 2.78;
    localparam int unsigned STEP_CYCLES = int'(STEP_MS * 1000.0 * CLK_MHZ);
    localparam int unsigned WAIT_STRETCH_FACTOR = 12;

    // full-scale counts per integration step
    localparam int unsigned COUNTS_PER_STEP_LOG2 = 10;
    localparam logic [15:0] RESULT_FULL_SCALE = 16'hffff;

    // measurement sequencer states
    typedef enum logic [2:0] {
        LSC_IDLE = 3'b001,
        LSC_INTEG = 3'b010,
        LSC_WAIT = 3'b100
    } lsc_state_t;

    // one access from the serial engine to the register file
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lsc_reg_req_t;

endpackage

/* testbench/lsc_host_model.sv */
// host processor model that writes and reads the cycle controller registers
module lsc_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output lsc_pkg::lsc_reg_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import lsc_pkg::*;

    initial req_o = '0;

    // one byte per call; the strobe stays up so bytes can follow back to back
    // parameters go in before measure-on, and power-on is set with it in one byte
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask

    // drop the strobe a cycle later so the last byte is taken only once
    task automatic idle();
        @(negedge clk_i);
        req_o.wr = 1'b0;
    endtask

    // read data is combinational, so it is taken at the rising edge after the address settles
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req_o = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule

/* testbench/test_light_sensor_cycle_control.sv */
// self-checking bench for the light sensor cycle controller
module test_light_sensor_cycle_control;
    timeunit 1ns;
    timeprecision 1ns;
    import lsc_pkg::*;

    // short step keeps the stretched wait at 96 cycles
    localparam int unsigned STEP = 4;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wait_stretch_i = 1'b0;
    logic int_enable_i = 1'b0;
    logic [3:0] persistence_count_i = 4'h0;
    logic [15:0] ch0_result_i = 16'h0000;
    logic int_clear_i = 1'b0;
    lsc_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic osc_run, measure_active, integrating, result_valid, light_int, int_pin_oe, autozero, int_pin;
    logic [15:0] ch0_value, low_limit;
    int fails = 0;
    int comparisons = 0;
    int az_seen = 0;

    always #25 clk_i = ~clk_i;

    // auto-zero pulses are counted as they pass, since they fall inside a measured phase
    always @(negedge clk_i) az_seen += (autozero === 1'b1);

    lsc_cycle_ctrl #(.STEP_CYCLES(STEP)) i_lsc_cycle_ctrl (
        .clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req), .reg_rdata_o(reg_rdata),
        .wait_stretch_i(wait_stretch_i), .int_enable_i(int_enable_i),
        .persistence_count_i(persistence_count_i), .ch0_result_i(ch0_result_i),
        .int_clear_i(int_clear_i), .osc_run_o(osc_run), .measure_active_o(measure_active),
        .integrating_o(integrating), .autozero_o(autozero), .result_valid_o(result_valid),
        .ch0_value_o(ch0_value), .low_limit_o(low_limit), .light_int_o(light_int),
        .int_pin_o(int_pin), .int_pin_oe_o(int_pin_oe)
    );

    lsc_host_model i_lsc_host_model (.clk_i(clk_i), .rdata_i(reg_rdata), .req_o(reg_req));

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr1(input logic [7:0] a, input logic [7:0] d);
        i_lsc_host_model.write(a, d);
        i_lsc_host_model.idle();
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        i_lsc_host_model.read(a, d);
        chk({8'h00, d}, {8'h00, exp}, what);
    endtask

    // waits for the integrating level, then counts how long it lasts; a hang ends the run
    task automatic measure(input logic lvl, output int n);
        int k;
        for (k = 0; k < 3000 && integrating !== lvl; k++) @(negedge clk_i);
        for (n = 0; n < 3000 && integrating === lvl; n++) @(negedge clk_i);
        if (k == 3000 || n == 3000) begin
            fails++;
            $display("wrong value at %0t ns: sequencer stuck", $time);
            print_verdict();
        end
    endtask

    // waits for the next result strobe; a hang ends the run
    task automatic next_result();
        int k;
        @(negedge clk_i);
        for (k = 0; k < 100 && result_valid !== 1'b1; k++) @(negedge clk_i);
        if (k == 100) begin
            fails++;
            $display("wrong value at %0t ns: no result strobe", $time);
            print_verdict();
        end
    endtask

    // reset values, reserved enable bits, unmapped address, measure-on without power
    task automatic t_regs();
        rd_chk(ADDR_POWER_AND_FUNCTION_ENABLE, 8'h00, "enable reset");
        rd_chk(ADDR_INTEGRATION_LENGTH, 8'h00, "integration reset");
        rd_chk(ADDR_WAIT_LENGTH, 8'h00, "wait reset");
        rd_chk(ADDR_LOW_LIMIT_LSB, 8'h00, "lsb reset");
        rd_chk(8'h82, 8'h00, "unmapped");
        wr1(ADDR_POWER_AND_FUNCTION_ENABLE, 8'hf4);
        rd_chk(ADDR_POWER_AND_FUNCTION_ENABLE, 8'h00, "reserved bits");
        wr1(ADDR_POWER_AND_FUNCTION_ENABLE, 8'h02);
        @(negedge clk_i);
        chk(16'(measure_active), 16'h0000, "no power");
        wr1(ADDR_POWER_AND_FUNCTION_ENABLE, 8'h01);
        chk(16'(osc_run), 16'h0001, "oscillator on");
        wr1(ADDR_POWER_AND_FUNCTION_ENABLE, 8'h00);
        chk(16'(osc_run), 16'h0000, "oscillator off");
        $display("test registers done");
    endtask

    // low byte is held until the high byte arrives
    task automatic t_thresh();
        i_lsc_host_model.write(ADDR_LOW_LIMIT_LSB, 8'hcd);
        i_lsc_host_model.write(ADDR_LOW_LIMIT_MSB, 8'h01);
        chk(low_limit, 16'h0000, "held lsb");
        i_lsc_host_model.idle();
        chk(low_limit, 16'h01cd, "applied pair");
        rd_chk(ADDR_LOW_LIMIT_LSB, 8'hcd, "lsb readback");
        rd_chk(ADDR_LOW_LIMIT_MSB, 8'h01, "msb readback");
        wr1(ADDR_LOW_LIMIT_LSB, 8'h34);
        chk(low_limit, 16'h01cd, "lsb alone");
        $display("test threshold done");
    endtask

    // integration, wait, stretch, saturation, interrupt and waitless repetition
    task automatic t_cycle();
        int n, k, low, pulses;
        wr1(ADDR_INTEGRATION_LENGTH, 8'h02);
        wr1(ADDR_WAIT_LENGTH, 8'h01);
        persistence_count_i = 4'h1;
        int_enable_i = 1'b1;
        ch0_result_i = 16'h01cc;
        wr1(ADDR_POWER_AND_FUNCTION_ENABLE, 8'h0b);
        measure(1'b1, n);
        chk(16'(n), 16'(3 * STEP), "integration length");
        chk(16'(result_valid), 16'h0001, "result strobe");
        chk(ch0_value, 16'h01cc, "result in range");
        chk(16'(light_int), 16'h0001, "below low limit");
        chk(16'(int_pin_oe), 16'h0001, "pin pulled");
        chk(16'(int_pin), 16'h0000, "pin driven low");
        int_clear_i = 1'b1;
        ch0_result_i = 16'h1000;
        @(negedge clk_i);
        int_clear_i = 1'b0;
        chk(16'(light_int), 16'h0000, "flag cleared");
        measure(1'b0, n);
        // the first wait cycle went to the clear check above, so it is added back
        chk(16'(n + 1), 16'(2 * STEP), "wait length");
        wait_stretch_i = 1'b1;
        measure(1'b1, n);
        chk(16'(n), 16'(3 * STEP), "second integration");
        chk(ch0_value, 16'h0bff, "saturated");
        chk(16'(light_int), 16'h0000, "above low limit");
        measure(1'b0, n);
        chk(16'(n), 16'(24 * STEP), "stretched wait");
        wr1(ADDR_POWER_AND_FUNCTION_ENABLE, 8'h03);
        low = 0;
        pulses = 0;
        // three integration periods with no wait between them
        for (k = 0; k < 36; k++) begin
            @(negedge clk_i);
            low += (integrating !== 1'b1);
            pulses += (result_valid === 1'b1);
        end
        chk(16'(low), 16'h0000, "no gap");
        chk(16'(pulses), 16'h0003, "back to back results");
        // persistence of two: the first result below the limit must not flag, the second must
        persistence_count_i = 4'h2;
        ch0_result_i = 16'h0100;
        next_result();
        chk(16'(light_int), 16'h0000, "first of two below");
        next_result();
        chk(16'(light_int), 16'h0001, "second of two below");
        chk(16'(az_seen), 16'h0001, "one auto-zero pass");
        wr1(ADDR_POWER_AND_FUNCTION_ENABLE, 8'h00);
        @(negedge clk_i);
        chk(16'(measure_active), 16'h0000, "stopped");
        $display("test cycle done");
    endtask

    initial begin
        repeat (5) @(negedge clk_i);
        reset_i = 1'b0;
        t_regs();
        t_thresh();
        t_cycle();
        print_verdict();
    end
endmodule
